// file: design/lo_cfg.svh
// Offsets, field positions, reset values and constants for the oscillator control register bank
`ifndef LO_CFG_SVH
`define LO_CFG_SVH

// ********************************************************
// Register indices (byte address is four times the index)
// ********************************************************
`define LO_GEN_RESET_IDX 10'h010
`define LO_GEN_CTRL_IDX 10'h011
`define LO_OFS_CTRL_IDX 10'h012
`define LO_OSC_CTRL_IDX 10'h025
`define LO_OSC_RDBK_IDX 10'hD5

// ********************************************************
// Bus shape
// ********************************************************
`define LO_ADDR_W 12
`define LO_DATA_W 32
`define LO_REG_W 8
`define LO_ALIGN_OK 2'h0
`define LO_RDATA_ZERO 32'h0000_0000
`define LO_UPPER_ZERO 24'h00_0000

// ********************************************************
// Reset values and field positions
// ********************************************************
`define LO_OSC_RESET 8'h00
`define LO_GEN_RESET 8'h00
`define LO_OFS_RESET 8'h00
`define LO_GEN_OSC_EN_BIT 3
`define LO_OFS_RANGE_DBL_BIT 2

// ********************************************************
// Transmit LO division factors
// ********************************************************
`define LO_DIV_FACTOR_1 3'h1
`define LO_DIV_FACTOR_2 3'h2
`define LO_DIV_FACTOR_4 3'h4
`define LO_DIV_FACTOR_6 3'h6

`endif

// file: design/lo_pkg.sv
// Types shared by the oscillator control register bank
package lo_pkg;

  typedef enum logic [1:0] {
    TX_DIV_2 = 2'h0,
    TX_DIV_4 = 2'h1,
    TX_DIV_6 = 2'h2,
    TX_DIV_1 = 2'h3
  } tx_div_t;

  typedef enum logic [1:0] {
    NR_MAXIMUM = 2'h0,
    NR_MID_HIGH = 2'h1,
    NR_MID_LOW = 2'h2,
    NR_MINIMUM = 2'h3
  } nr_level_t;

  // Bit order matches the register, bit 7 first
  typedef struct packed {
    logic filter_cal_disable;
    tx_div_t tx_lo_divide_sel;
    logic lo_input_power;
    nr_level_t neg_resistance_level;
    logic nr_amplifier_power;
    logic oscillator_buffer_power;
  } lo_ctrl_t;

  typedef struct packed {
    logic filter_cal_disable;
    tx_div_t tx_lo_divide;
    logic [2:0] tx_lo_divide_factor;
    logic lo_input_power;
    nr_level_t neg_resistance_level;
    logic nr_amplifier_power;
    logic nr_amplifier_bypass;
    logic oscillator_buffer_power;
  } lo_drive_t;

endpackage

// file: design/lo_field_decode.sv
// Turns the stored oscillator control byte into registered analog control levels
`timescale 1ns/1ns
`include "lo_cfg.svh"

module lo_field_decode
  import lo_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire lo_ctrl_t osc_ctrl_i,
  input wire logic enable_i,
  output lo_drive_t drive_o
);

  // ********************************************************
  // Gated fields
  // ********************************************************
  // With the section disabled every field falls to its zero code
  wire lo_ctrl_t gated_ctrl = enable_i ? osc_ctrl_i : lo_ctrl_t'(`LO_OSC_RESET); // R1

  logic [2:0] factor_sel;
  always_comb begin
    unique case (gated_ctrl.tx_lo_divide_sel) // R5
      TX_DIV_2: factor_sel = `LO_DIV_FACTOR_2;
      TX_DIV_4: factor_sel = `LO_DIV_FACTOR_4;
      TX_DIV_6: factor_sel = `LO_DIV_FACTOR_6;
      TX_DIV_1: factor_sel = `LO_DIV_FACTOR_1;
    endcase
  end

  lo_drive_t drive_nxt;
  always_comb begin
    drive_nxt.filter_cal_disable = gated_ctrl.filter_cal_disable; // R4
    drive_nxt.tx_lo_divide = gated_ctrl.tx_lo_divide_sel; // R5
    drive_nxt.tx_lo_divide_factor = factor_sel;
    drive_nxt.lo_input_power = gated_ctrl.lo_input_power; // R6
    drive_nxt.neg_resistance_level = gated_ctrl.neg_resistance_level; // R9
    drive_nxt.nr_amplifier_power = gated_ctrl.nr_amplifier_power; // R6
    drive_nxt.nr_amplifier_bypass = ~gated_ctrl.nr_amplifier_power; // R7
    drive_nxt.oscillator_buffer_power = gated_ctrl.oscillator_buffer_power; // R6
  end

  // ********************************************************
  // Output flops
  // ********************************************************
  // Registered so the analog controls never see decode glitches
  lo_drive_t drive_r;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      drive_r <= '{filter_cal_disable: 1'h0, tx_lo_divide: TX_DIV_2, tx_lo_divide_factor: `LO_DIV_FACTOR_2,
                   lo_input_power: 1'h0, neg_resistance_level: NR_MAXIMUM, nr_amplifier_power: 1'h0,
                   nr_amplifier_bypass: 1'h1, oscillator_buffer_power: 1'h0};
    end else begin
      drive_r <= drive_nxt;
    end
  end

  assign drive_o = drive_r;

endmodule // lo_field_decode

// file: design/vco_lo_control_register.sv
// APB register bank for the oscillator and LO control of a direct-conversion receiver
//
// Functional notes
// R1 - Oscillator fields act only while general control bit 3 is one.
// R2 - General reset command clears the whole oscillator control register.
// R3 - Eight-bit write-only register, separate read-only location returns last value written.
// R4 - Top bit one disables filter calibration; zero keeps it active.
// R5 - Divider bits: 00 by two, 01 by four, 10 by six, 11 undivided.
// R6 - Bits 4, 1, 0 power LO input, NR amplifier, buffer when one.
// R7 - NR amplifier disabled means it is bypassed for an external LO.
// R8 - Software should not enable LO input and oscillator together; not enforced.
// R9 - NR level: 00 maximum, 01 and 10 intermediate, 11 minimum.
// R10 - Offset control bit 2 enlarges the dc offset correction range.
// R11 - One write updates all six fields; readback returns that byte next read.
`timescale 1ns/1ns
`include "lo_cfg.svh"

module vco_lo_control_register
  import lo_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`LO_ADDR_W-1:0] paddr_i,
  input wire logic [`LO_DATA_W-1:0] pwdata_i,
  output logic [`LO_DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output lo_drive_t lo_drive_o,
  output logic osc_section_enable_o,
  output logic offset_range_double_o
);

  // ********************************************************
  // APB phase and address decode
  // ********************************************************
  wire apb_setup = psel_i & ~penable_i;
  wire apb_access = psel_i & penable_i;
  wire [9:0] word_idx = paddr_i[`LO_ADDR_W-1:2];
  wire addr_aligned = (paddr_i[1:0] == `LO_ALIGN_OK);

  wire hit_gen_reset = addr_aligned & (word_idx == `LO_GEN_RESET_IDX);
  wire hit_gen_ctrl = addr_aligned & (word_idx == `LO_GEN_CTRL_IDX);
  wire hit_ofs_ctrl = addr_aligned & (word_idx == `LO_OFS_CTRL_IDX);
  wire hit_osc_ctrl = addr_aligned & (word_idx == `LO_OSC_CTRL_IDX);
  wire hit_osc_rdbk = addr_aligned & (word_idx == `LO_OSC_RDBK_IDX);
  wire hit_any = hit_gen_reset | hit_gen_ctrl | hit_ofs_ctrl | hit_osc_ctrl | hit_osc_rdbk;

  // Read data is captured in the setup cycle, so the access phase can close at once
  assign pready_o = 1'h1;
  assign pslverr_o = apb_access & ~hit_any;

  wire wr_fire = apb_access & pwrite_i;
  wire wr_gen_reset = wr_fire & hit_gen_reset;
  wire wr_gen_ctrl = wr_fire & hit_gen_ctrl;
  wire wr_ofs_ctrl = wr_fire & hit_ofs_ctrl;
  wire wr_osc_ctrl = wr_fire & hit_osc_ctrl;
  wire [`LO_REG_W-1:0] wr_byte = pwdata_i[`LO_REG_W-1:0];

  // ********************************************************
  // Registers
  // ********************************************************
  logic [`LO_REG_W-1:0] gen_ctrl_r;
  logic [`LO_REG_W-1:0] gen_ctrl_nxt;
  logic [`LO_REG_W-1:0] ofs_ctrl_r;
  logic [`LO_REG_W-1:0] ofs_ctrl_nxt;
  lo_ctrl_t osc_ctrl_r;
  lo_ctrl_t osc_ctrl_nxt;

  // The reset command clears every control register, not only the oscillator one
  assign gen_ctrl_nxt = wr_gen_reset ? `LO_GEN_RESET : (wr_gen_ctrl ? wr_byte : gen_ctrl_r);
  assign ofs_ctrl_nxt = wr_gen_reset ? `LO_OFS_RESET : (wr_ofs_ctrl ? wr_byte : ofs_ctrl_r);
  // Whole byte is loaded at once, never field by field
  assign osc_ctrl_nxt = wr_gen_reset ? lo_ctrl_t'(`LO_OSC_RESET) : // R2
                        (wr_osc_ctrl ? lo_ctrl_t'(wr_byte) : osc_ctrl_r); // R11

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      gen_ctrl_r <= `LO_GEN_RESET;
      ofs_ctrl_r <= `LO_OFS_RESET;
      osc_ctrl_r <= lo_ctrl_t'(`LO_OSC_RESET);
    end else begin
      gen_ctrl_r <= gen_ctrl_nxt;
      ofs_ctrl_r <= ofs_ctrl_nxt;
      osc_ctrl_r <= osc_ctrl_nxt;
    end
  end

  // ********************************************************
  // Read path
  // ********************************************************
  // The control location itself is write-only and reads as zero
  wire [`LO_REG_W-1:0] rd_byte = hit_osc_rdbk ? osc_ctrl_r : // R3
                                 hit_gen_ctrl ? gen_ctrl_r :
                                 hit_ofs_ctrl ? ofs_ctrl_r : `LO_OSC_RESET;
  wire rd_capture = apb_setup & ~pwrite_i;

  logic [`LO_DATA_W-1:0] prdata_r;
  logic [`LO_DATA_W-1:0] prdata_nxt;
  assign prdata_nxt = rd_capture ? {`LO_UPPER_ZERO, rd_byte} : prdata_r;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prdata_r <= `LO_RDATA_ZERO;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata_o = prdata_r;

  // ********************************************************
  // Analog control outputs
  // ********************************************************
  wire osc_enable = gen_ctrl_r[`LO_GEN_OSC_EN_BIT]; // R1

  logic osc_enable_r;
  logic range_double_r;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      osc_enable_r <= 1'h0;
      range_double_r <= 1'h0;
    end else begin
      osc_enable_r <= osc_enable;
      range_double_r <= ofs_ctrl_r[`LO_OFS_RANGE_DBL_BIT]; // R10
    end
  end

  assign osc_section_enable_o = osc_enable_r;
  assign offset_range_double_o = range_double_r;

  // Both LO input and oscillator may be powered at once; software is trusted to avoid it
  lo_field_decode u_decode (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .osc_ctrl_i(osc_ctrl_r),
    .enable_i(osc_enable),
    .drive_o(lo_drive_o)
  );

  // ********************************************************
  // Assertions
  // ********************************************************
  sequence osc_write_s;
    wr_osc_ctrl && !wr_gen_reset;
  endsequence

  sequence gen_reset_s;
    wr_gen_reset;
  endsequence

  sequence rdbk_read_s;
    apb_setup && !pwrite_i && hit_osc_rdbk;
  endsequence

  sequence ofs_write_s;
    wr_ofs_ctrl;
  endsequence

  property gated_off_p;
    @(posedge clk_i) disable iff (reset_i)
      !osc_enable |=> (!lo_drive_o.lo_input_power && !lo_drive_o.nr_amplifier_power &&
                       !lo_drive_o.oscillator_buffer_power && !lo_drive_o.filter_cal_disable &&
                       lo_drive_o.tx_lo_divide == TX_DIV_2 && lo_drive_o.neg_resistance_level == NR_MAXIMUM);
  endproperty

  gated_off_a: assert property (gated_off_p) // R1
    else $error("oscillator fields applied while section disabled");

  gen_reset_clear_a: assert property ( // R2
    @(posedge clk_i) disable iff (reset_i)
      gen_reset_s |=> (osc_ctrl_r == lo_ctrl_t'(`LO_OSC_RESET)) ##1 (!lo_drive_o.lo_input_power &&
        !lo_drive_o.nr_amplifier_power && !lo_drive_o.oscillator_buffer_power))
    else $error("general reset did not clear oscillator control");

  readback_value_a: assert property ( // R3
    @(posedge clk_i) disable iff (reset_i)
      rdbk_read_s |=> (prdata_o == {`LO_UPPER_ZERO, osc_ctrl_r}) && pready_o && !pslverr_o)
    else $error("readback location did not return oscillator control");

  write_only_read_a: assert property ( // R3
    @(posedge clk_i) disable iff (reset_i)
      (apb_setup && !pwrite_i && hit_osc_ctrl) |=> (prdata_o == `LO_RDATA_ZERO))
    else $error("write-only location returned data");

  filter_cal_a: assert property ( // R4
    @(posedge clk_i) disable iff (reset_i)
      osc_enable |=> (lo_drive_o.filter_cal_disable == $past(osc_ctrl_r.filter_cal_disable)))
    else $error("filter calibration disable does not follow bit 7");

  tx_divide_a: assert property ( // R5
    @(posedge clk_i) disable iff (reset_i)
      ((osc_enable && osc_ctrl_r.tx_lo_divide_sel == TX_DIV_6) |=>
        (lo_drive_o.tx_lo_divide_factor == `LO_DIV_FACTOR_6)) and
      ((osc_enable && osc_ctrl_r.tx_lo_divide_sel == TX_DIV_1) |=>
        (lo_drive_o.tx_lo_divide_factor == `LO_DIV_FACTOR_1)))
    else $error("transmit LO division factor wrong");

  tx_divide_two_a: assert property ( // R5
    @(posedge clk_i) disable iff (reset_i)
      (osc_enable && osc_ctrl_r.tx_lo_divide_sel == TX_DIV_2) ##1
        (lo_drive_o.tx_lo_divide_factor != `LO_DIV_FACTOR_2) |-> 1'h0)
    else $error("divide-by-two code not applied");

  tx_divide_four_a: assert property ( // R5
    @(posedge clk_i) disable iff (reset_i)
      (osc_enable && osc_ctrl_r.tx_lo_divide_sel == TX_DIV_4) |=>
        (lo_drive_o.tx_lo_divide_factor == `LO_DIV_FACTOR_4))
    else $error("divide-by-four code not applied");

  power_bits_a: assert property ( // R6
    @(posedge clk_i) disable iff (reset_i)
      osc_enable |=> (lo_drive_o.lo_input_power == $past(osc_ctrl_r.lo_input_power)) &&
        (lo_drive_o.nr_amplifier_power == $past(osc_ctrl_r.nr_amplifier_power)) &&
        (lo_drive_o.oscillator_buffer_power == $past(osc_ctrl_r.oscillator_buffer_power)))
    else $error("power enable does not follow its bit");

  bypass_a: assert property ( // R7
    @(posedge clk_i) disable iff (reset_i)
      lo_drive_o.nr_amplifier_bypass != lo_drive_o.nr_amplifier_power)
    else $error("NR amplifier neither powered nor bypassed");

  nr_level_a: assert property ( // R9
    @(posedge clk_i) disable iff (reset_i)
      osc_enable |=> (lo_drive_o.neg_resistance_level == $past(osc_ctrl_r.neg_resistance_level)))
    else $error("negative resistance level not applied");

  range_double_a: assert property ( // R10
    @(posedge clk_i) disable iff (reset_i)
      ofs_write_s ##1 1'h1 |=> (offset_range_double_o == $past(ofs_ctrl_r[`LO_OFS_RANGE_DBL_BIT])))
    else $error("range double output does not follow bit 2");

  whole_byte_a: assert property ( // R11
    @(posedge clk_i) disable iff (reset_i)
      osc_write_s |=> (osc_ctrl_r == lo_ctrl_t'($past(wr_byte))))
    else $error("oscillator control byte not loaded whole");

  write_then_read_a: assert property ( // R11
    @(posedge clk_i) disable iff (reset_i)
      osc_write_s ##1 (!wr_fire [*2]) ##0 rdbk_read_s |=> (prdata_o[`LO_REG_W-1:0] == osc_ctrl_r))
    else $error("readback after write returned another byte");

  unmapped_err_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
      (apb_access && !hit_any) |-> pslverr_o ##1 (gen_ctrl_r == $past(gen_ctrl_r)))
    else $error("unmapped access not refused");

  // ********************************************************
  // Bus and register assertions
  // ********************************************************
  sequence gen_write_s;
    wr_gen_ctrl;
  endsequence

  sequence rdbk_write_s;
    wr_fire && hit_osc_rdbk;
  endsequence

  sequence osc_idle_s;
    !wr_osc_ctrl && !wr_gen_reset;
  endsequence

  err_in_access_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
      pslverr_o |-> apb_access)
    else $error("error response outside access phase");

  rdata_upper_a: assert property ( // R3
    @(posedge clk_i) disable iff (reset_i)
      prdata_o[`LO_DATA_W-1:`LO_REG_W] == `LO_UPPER_ZERO)
    else $error("read data above the register byte not zero");

  err_read_zero_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
      (apb_setup && !pwrite_i && !hit_any) |=> (prdata_o == `LO_RDATA_ZERO))
    else $error("refused read returned data");

  rdata_hold_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
      !rd_capture |=> (prdata_o == $past(prdata_o)))
    else $error("read data changed without a read");

  reset_clears_a: assert property (
    @(posedge clk_i)
      reset_i |=> (osc_ctrl_r == lo_ctrl_t'(`LO_OSC_RESET)) && (prdata_o == `LO_RDATA_ZERO) &&
        !osc_section_enable_o && !offset_range_double_o)
    else $error("reset did not clear the register bank");

  gen_write_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
      gen_write_s |=> (gen_ctrl_r == $past(wr_byte)))
    else $error("general control write not loaded");

  gen_reset_all_a: assert property ( // R2
    @(posedge clk_i) disable iff (reset_i)
      gen_reset_s |=> (gen_ctrl_r == `LO_GEN_RESET) && (ofs_ctrl_r == `LO_OFS_RESET))
    else $error("general reset left a control register set");

  rdbk_write_ignored_a: assert property ( // R3
    @(posedge clk_i) disable iff (reset_i)
      rdbk_write_s |=> (osc_ctrl_r == $past(osc_ctrl_r)))
    else $error("write to readback location changed the register");

  osc_hold_a: assert property ( // R11
    @(posedge clk_i) disable iff (reset_i)
      osc_idle_s |=> (osc_ctrl_r == $past(osc_ctrl_r)))
    else $error("oscillator control changed without a write");

  unaligned_write_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
      (wr_fire && !addr_aligned) |=> (gen_ctrl_r == $past(gen_ctrl_r)) &&
        (ofs_ctrl_r == $past(ofs_ctrl_r)) && (osc_ctrl_r == $past(osc_ctrl_r)))
    else $error("misaligned write changed a register");

  section_enable_a: assert property ( // R1
    @(posedge clk_i) disable iff (reset_i)
      1'h1 |=> (osc_section_enable_o == $past(gen_ctrl_r[`LO_GEN_OSC_EN_BIT])))
    else $error("section enable output does not follow bit 3");

  bypass_gated_a: assert property ( // R7
    @(posedge clk_i) disable iff (reset_i)
      !osc_enable |=> lo_drive_o.nr_amplifier_bypass)
    else $error("NR amplifier not bypassed while section disabled");

  range_follow_a: assert property ( // R10
    @(posedge clk_i) disable iff (reset_i)
      1'h1 |=> (offset_range_double_o == $past(ofs_ctrl_r[`LO_OFS_RANGE_DBL_BIT])))
    else $error("range double output does not track bit 2");

endmodule // vco_lo_control_register

// file: dv/vco_lo_control_register_tb.sv
// Self-checking testbench for the oscillator control register bank
`timescale 1ns/1ns
`include "lo_cfg.svh"

module vco_lo_control_register_tb import lo_pkg::*;;
  // ********************************************************
  // Bench signals
  // ********************************************************
  localparam logic [11:0] A_RST = {`LO_GEN_RESET_IDX, 2'h0};
  localparam logic [11:0] A_GEN = {`LO_GEN_CTRL_IDX, 2'h0};
  localparam logic [11:0] A_OFS = {`LO_OFS_CTRL_IDX, 2'h0};
  localparam logic [11:0] A_OSC = {`LO_OSC_CTRL_IDX, 2'h0};
  localparam logic [11:0] A_RDBK = {`LO_OSC_RDBK_IDX, 2'h0};
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  lo_drive_t lo_drive_o;
  logic osc_section_enable_o;
  logic offset_range_double_o;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;

  vco_lo_control_register dut (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .lo_drive_o(lo_drive_o),
    .osc_section_enable_o(osc_section_enable_o),
    .offset_range_double_o(offset_range_double_o)
  );

  always #4 clk_i = ~clk_i;

  // Hang guard, well above the hundred or so cycles the tests need
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail = n_fail + 1;
      summarize();
    end
  end

  // ********************************************************
  // Helpers
  // ********************************************************
  task automatic summarize();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Idle cycle in front, so no bus signal is assigned twice in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Wait states are the slave's choice; only the bench timeout ends this wait
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  function automatic lo_drive_t exp_drive(input logic [7:0] v, input logic en);
    lo_drive_t d;
    if (!en) v = 8'h00;
    d.filter_cal_disable = v[7];
    d.tx_lo_divide = tx_div_t'(v[6:5]);
    case (v[6:5])
      2'h0: d.tx_lo_divide_factor = `LO_DIV_FACTOR_2;
      2'h1: d.tx_lo_divide_factor = `LO_DIV_FACTOR_4;
      2'h2: d.tx_lo_divide_factor = `LO_DIV_FACTOR_6;
      default: d.tx_lo_divide_factor = `LO_DIV_FACTOR_1;
    endcase
    d.lo_input_power = v[4];
    d.neg_resistance_level = nr_level_t'(v[3:2]);
    d.nr_amplifier_power = v[1];
    d.nr_amplifier_bypass = ~v[1];
    d.oscillator_buffer_power = v[0];
    return d;
  endfunction

  // Write, read the mirror at once, then compare the decoded outputs
  task automatic osc_check(input logic [7:0] v, input logic en);
    apb(1'b1, A_OSC, {24'h00_0000, v});
    chk({31'h0, err}, 32'h0, "osc write error");
    apb(1'b0, A_RDBK, 32'h0);
    chk(rd, {24'h00_0000, v}, "readback");
    @(negedge clk_i);
    chk({19'h0, lo_drive_o}, {19'h0, exp_drive(v, en)}, "drive");
  endtask

  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic t_reset();
    @(negedge clk_i);
    chk({19'h0, lo_drive_o}, {19'h0, exp_drive(8'h00, 1'b0)}, "reset drive");
    chk({31'h0, osc_section_enable_o}, 32'h0, "reset enable");
    apb(1'b0, A_RDBK, 32'h0);
    chk(rd, 32'h0000_0000, "reset readback");
    $display("test reset done");
  endtask

  task automatic t_gate();
    osc_check(8'hEF, 1'b0);
    $display("test gate done");
  endtask

  task automatic t_fields();
    logic [7:0] vals [5];
    vals = '{8'h90, 8'h26, 8'h49, 8'h6C, 8'h00};
    apb(1'b1, A_GEN, 32'h0000_0008);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({31'h0, osc_section_enable_o}, 32'h1, "section enable");
    // Covers every divider and level code, each power bit both ways
    foreach (vals[i]) osc_check(vals[i], 1'b1);
    $display("test fields done");
  endtask

  task automatic t_offset();
    apb(1'b1, A_OFS, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({31'h0, offset_range_double_o}, 32'h1, "range double set");
    apb(1'b1, A_OFS, 32'h0000_00FB);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({31'h0, offset_range_double_o}, 32'h0, "range double clear");
    $display("test offset done");
  endtask

  task automatic t_refuse();
    apb(1'b0, A_OSC, 32'h0);
    chk({err, rd[30:0]}, 32'h0, "write-only read");
    apb(1'b1, A_RDBK, 32'h0000_0055);
    chk({31'h0, err}, 32'h0, "readback write error");
    apb(1'b0, A_RDBK, 32'h0);
    chk(rd, 32'h0000_0000, "readback unchanged");
    apb(1'b1, 12'h3FC, 32'h0000_00FF);
    chk({31'h0, err}, 32'h1, "unmapped write");
    apb(1'b0, A_OSC + 12'h001, 32'h0);
    chk({31'h0, err}, 32'h1, "misaligned read");
    chk(rd, 32'h0000_0000, "misaligned data");
    apb(1'b1, A_OSC + 12'h002, 32'h0000_0003);
    chk({31'h0, err}, 32'h1, "misaligned write");
    apb(1'b0, A_RDBK, 32'h0);
    chk(rd, 32'h0000_0000, "misaligned write ignored");
    $display("test refuse done");
  endtask

  task automatic t_genreset();
    apb(1'b1, A_GEN, 32'h0000_0008);
    osc_check(8'hA3, 1'b1);
    apb(1'b1, A_RST, 32'h0000_005A);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk({19'h0, lo_drive_o}, {19'h0, exp_drive(8'h00, 1'b0)}, "cleared drive");
    apb(1'b0, A_RDBK, 32'h0);
    chk(rd, 32'h0000_0000, "cleared readback");
    $display("test general reset done");
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_gate();
    t_fields();
    t_offset();
    t_refuse();
    t_genreset();
    summarize();
  end
endmodule // vco_lo_control_register_tb
